// file: core/rct_defines.vh
`ifndef RCT_DEFINES_VH
`define RCT_DEFINES_VH

// Register offsets on the two-wire serial interface
`define RCT_OFS_MAIN_CTRL 8'h00
`define RCT_OFS_IRQ_EN 8'h01
`define RCT_OFS_IRQ_FLAGS 8'h02
`define RCT_OFS_COUNT_LO 8'h18
`define RCT_OFS_COUNT_HI 8'h19

// Field positions in the main control register
`define RCT_BIT_RUN 1
`define RCT_BIT_RELOAD 2
`define RCT_BIT_SEL_LO 5
`define RCT_BIT_SEL_HI 6

// Field positions in the interrupt enable and flag registers
`define RCT_BIT_IRQ_EN 1
`define RCT_BIT_DONE 1

// Reset values
`define RCT_RST_SEL 2'h0
`define RCT_RST_COUNT 16'h0000
`define RCT_RST_BYTE 8'h00

// Tick select codes
`define RCT_SEL_32HZ 2'h0
`define RCT_SEL_8HZ 2'h1
`define RCT_SEL_1HZ 2'h2
`define RCT_SEL_HALF_HZ 2'h3

// Prescaler terminal masks over oscillator edges at 32768 Hz
`define RCT_DIV_32HZ 16'h03ff
`define RCT_DIV_8HZ 16'h0fff
`define RCT_DIV_1HZ 16'h7fff
`define RCT_DIV_HALF_HZ 16'hffff

// Default seven-bit device address on the serial bus (arbitrary value)
`define RCT_DEV_ADDR 7'h52

// Serial slave bit count per byte
`define RCT_BITS_PER_BYTE 4'h8

`endif

// file: core/rct_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser, one stage pair per bit
module rct_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire resetn,
  input wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // First stage feeds only the second stage
      reg meta_r;
      reg sync_r;
      always @(posedge clk) begin
        if (!resetn) begin
          meta_r <= 1'b1;
          sync_r <= 1'b1;
        end else begin
          meta_r <= d_in[i];
          sync_r <= meta_r;
        end
      end
      assign q_out[i] = sync_r;
    end
  endgenerate
endmodule

// file: core/rct_tick_div.v
`timescale 1ns/1ps
`include "rct_defines.vh"
// Divides the synchronised 32.768 kHz oscillator into countdown ticks
module rct_tick_div (
  input wire clk,
  input wire resetn,
  input wire osc_sync,
  input wire [1:0] sel,
  output reg tick
);
  reg osc_d_r;      // Delayed oscillator level for edge detection
  reg [15:0] div_r; // Free running oscillator edge counter
  reg [15:0] mask;  // Terminal mask for the chosen rate
  wire osc_edge;

  assign osc_edge = osc_sync & ~osc_d_r;

  // Rate select; a free running divider means the first tick after a
  // start may come early by up to one tick period, like a real prescaler
  always @* begin
    case (sel)
      `RCT_SEL_32HZ: mask = `RCT_DIV_32HZ;
      `RCT_SEL_8HZ: mask = `RCT_DIV_8HZ;
      `RCT_SEL_1HZ: mask = `RCT_DIV_1HZ;
      default: mask = `RCT_DIV_HALF_HZ;
    endcase
  end

  // Counter and one-cycle tick pulse
  always @(posedge clk) begin
    if (!resetn) begin
      // Matches the synchroniser's reset level, so no false edge follows reset
      osc_d_r <= 1'b1;
      div_r <= 16'h0000;
      tick <= 1'b0;
    end else begin
      osc_d_r <= osc_sync;
      tick <= 1'b0;
      if (osc_edge) begin
        div_r <= div_r + 16'h0001;
        tick <= ((div_r & mask) == mask);
      end
    end
  end
endmodule

// file: core/rct_timer.v
`timescale 1ns/1ps
`include "rct_defines.vh"
// Behaviour
// - Timer counts only while run bit set
// - Select field picks 32, 8, 1, 0.5 Hz
// - Sixteen-bit count from low and high registers
// - Zero count keeps timer from ever finishing
// - Reaching zero ends a countdown period
// - Auto-reload restarts the period automatically
// - Reload costs one extra tick per period
// - Period end sets done flag if enabled
// - Disabled interrupt enable blocks flag and interrupt
// - Interrupt output follows the done flag
// - Flag holds until software writes zero
// - Select and reload writable only when stopped
// - Count writable only when stopped, no reload
// - Reset clears run, reload, selects 32 Hz
// - Interrupt pin is active low open drain
// - Unused enable and flag bits read zero
module rct_timer #(
  parameter [6:0] DEV_ADDR = `RCT_DEV_ADDR
) (
  input wire clk,
  input wire resetn,
  input wire osc_32k,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  output reg int_n_o,
  output reg int_n_oe
);
  // Serial slave states
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_AACK = 3'd2;
  localparam [2:0] ST_WRITE = 3'd3;
  localparam [2:0] ST_WACK = 3'd4;
  localparam [2:0] ST_READ = 3'd5;
  localparam [2:0] ST_RACK = 3'd6;

  // Synchronised pins
  wire [2:0] pins_sync;
  wire scl_s;
  wire sda_s;
  wire osc_s;
  reg scl_d_r;       // Previous scl level
  reg sda_d_r;       // Previous sda level
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;

  // Serial slave state
  reg [2:0] st_r;     // Slave state
  reg [3:0] bit_r;    // Bits seen in the current byte
  reg [7:0] sh_r;     // Shift register
  reg [7:0] ptr_r;    // Register pointer, auto-incrementing
  reg first_r;        // Next written byte is the pointer
  reg rd_r;           // Transfer direction is read
  reg mnack_r;        // Master refused the last read byte
  reg wr_stb_r;       // One-cycle register write strobe
  reg [7:0] wr_addr_r;
  reg [7:0] wr_data_r;
  reg [7:0] rd_data;  // Read mux output

  // Register state
  reg run_r;          // Timer run bit
  reg reload_r;       // Auto-reload bit
  reg [1:0] sel_r;    // Tick select field
  reg irq_en_r;       // Countdown interrupt enable
  reg done_flag_r;    // Countdown-done flag
  reg [15:0] load_r;  // Software-loaded count
  reg [15:0] cnt_r;   // Running count
  reg run_d_r;        // Run bit one cycle ago, for start detection
  reg done_nxt;       // Countdown reached zero this cycle
  reg flag_nxt;       // Next value of the done flag
  wire tick;
  wire wr_ctrl;
  wire wr_flags;

  rct_sync #(
    .W(3)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d_in({osc_32k, sda_i, scl_i}),
    .q_out(pins_sync)
  );

  assign scl_s = pins_sync[0];
  assign sda_s = pins_sync[1];
  assign osc_s = pins_sync[2];

  rct_tick_div u_div (
    .clk(clk),
    .resetn(resetn),
    .osc_sync(osc_s),
    .sel(sel_r),
    .tick(tick)
  );

  // Bus edge and condition detection on synchronised levels only
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // Read mux; unknown offsets read zero
  always @* begin
    rd_data = 8'h00;
    case (ptr_r)
      `RCT_OFS_MAIN_CTRL: begin
        rd_data[`RCT_BIT_RUN] = run_r;
        rd_data[`RCT_BIT_RELOAD] = reload_r;
        rd_data[`RCT_BIT_SEL_LO] = sel_r[0];
        rd_data[`RCT_BIT_SEL_HI] = sel_r[1];
      end
      `RCT_OFS_IRQ_EN: rd_data[`RCT_BIT_IRQ_EN] = irq_en_r;
      `RCT_OFS_IRQ_FLAGS: rd_data[`RCT_BIT_DONE] = done_flag_r;
      `RCT_OFS_COUNT_LO: rd_data = load_r[7:0];
      `RCT_OFS_COUNT_HI: rd_data = load_r[15:8];
      default: rd_data = 8'h00;
    endcase
  end

  // Serial slave: samples on scl rise, drives sda after scl fall
  always @(posedge clk) begin
    if (!resetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      st_r <= ST_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      first_r <= 1'b1;
      rd_r <= 1'b0;
      mnack_r <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      wr_stb_r <= 1'b0;
      sda_o <= 1'b0;
      if (start_det) begin
        // Start or repeated start: listen for the address
        st_r <= ST_ADDR;
        bit_r <= 4'h0;
        first_r <= 1'b1;
        sda_oe <= 1'b0;
      end else if (stop_det) begin
        st_r <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st_r)
          ST_ADDR: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s};
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == `RCT_BITS_PER_BYTE) begin
              bit_r <= 4'h0;
              if (sh_r[7:1] == DEV_ADDR) begin
                // Address match: acknowledge
                rd_r <= sh_r[0];
                sda_oe <= 1'b1;
                st_r <= ST_AACK;
              end else begin
                st_r <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              bit_r <= 4'h0;
              if (rd_r) begin
                // Present the first read bit
                sh_r <= rd_data;
                sda_oe <= ~rd_data[7];
                st_r <= ST_READ;
              end else begin
                sda_oe <= 1'b0;
                st_r <= ST_WRITE;
              end
            end
          end
          ST_WRITE: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s};
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == `RCT_BITS_PER_BYTE) begin
              bit_r <= 4'h0;
              sda_oe <= 1'b1;
              st_r <= ST_WACK;
              if (first_r) begin
                // First byte sets the pointer
                ptr_r <= sh_r;
                first_r <= 1'b0;
              end else begin
                wr_stb_r <= 1'b1;
                wr_addr_r <= ptr_r;
                wr_data_r <= sh_r;
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              st_r <= ST_WRITE;
            end
          end
          ST_READ: begin
            if (scl_rise) begin
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall) begin
              if (bit_r == `RCT_BITS_PER_BYTE) begin
                // Release sda for the master's acknowledge
                sda_oe <= 1'b0;
                ptr_r <= ptr_r + 8'h01;
                st_r <= ST_RACK;
              end else begin
                sh_r <= {sh_r[6:0], 1'b0};
                sda_oe <= ~sh_r[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mnack_r <= sda_s;
            end else if (scl_fall) begin
              bit_r <= 4'h0;
              if (mnack_r) begin
                st_r <= ST_IDLE;
              end else begin
                sh_r <= rd_data;
                sda_oe <= ~rd_data[7];
                st_r <= ST_READ;
              end
            end
          end
          default: begin
            sda_oe <= 1'b0;
            st_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign wr_ctrl = wr_stb_r && (wr_addr_r == `RCT_OFS_MAIN_CTRL);
  assign wr_flags = wr_stb_r && (wr_addr_r == `RCT_OFS_IRQ_FLAGS);

  // Countdown step and flag next value
  always @* begin
    done_nxt = 1'b0;
    // The start cycle loads the count, so a stale count of one cannot end it
    if (run_r && run_d_r && tick && cnt_r == 16'h0001) begin
      done_nxt = 1'b1;
    end
    flag_nxt = done_flag_r;
    if (wr_flags && !wr_data_r[`RCT_BIT_DONE]) begin
      flag_nxt = 1'b0;
    end
    // A period end in the clearing cycle still sets the flag
    if (done_nxt && irq_en_r) begin
      flag_nxt = 1'b1;
    end
  end

  // Control registers, count and interrupt pin
  always @(posedge clk) begin
    if (!resetn) begin
      run_r <= 1'b0;
      reload_r <= 1'b0;
      sel_r <= `RCT_RST_SEL;
      irq_en_r <= 1'b0;
      done_flag_r <= 1'b0;
      load_r <= `RCT_RST_COUNT;
      cnt_r <= `RCT_RST_COUNT;
      run_d_r <= 1'b0;
      int_n_o <= 1'b0;
      int_n_oe <= 1'b0;
    end else begin
      run_d_r <= run_r;
      done_flag_r <= flag_nxt;
      // Pin only ever pulls low; released means pull-up idles it high
      int_n_o <= 1'b0;
      int_n_oe <= flag_nxt;
      if (wr_ctrl) begin
        run_r <= wr_data_r[`RCT_BIT_RUN];
        if (!run_r) begin
          // Rate and mode are locked while the timer runs
          reload_r <= wr_data_r[`RCT_BIT_RELOAD];
          sel_r <= {wr_data_r[`RCT_BIT_SEL_HI], wr_data_r[`RCT_BIT_SEL_LO]};
        end
      end
      if (wr_stb_r && wr_addr_r == `RCT_OFS_IRQ_EN) begin
        irq_en_r <= wr_data_r[`RCT_BIT_IRQ_EN];
      end
      // Count writes land only when stopped and not reloading
      if (wr_stb_r && !run_r && !reload_r) begin
        if (wr_addr_r == `RCT_OFS_COUNT_LO) begin
          load_r[7:0] <= wr_data_r;
        end
        if (wr_addr_r == `RCT_OFS_COUNT_HI) begin
          load_r[15:8] <= wr_data_r;
        end
      end
      if (run_r && !run_d_r) begin
        // Starting the timer takes the stored count
        cnt_r <= load_r;
      end else if (run_r && tick) begin
        if (cnt_r != 16'h0000) begin
          cnt_r <= cnt_r - 16'h0001;
        end else if (reload_r) begin
          // The reload uses up one tick of its own
          cnt_r <= load_r;
        end
      end
    end
  end
endmodule

// file: test/rct_timer_asserts.sv
`timescale 1ns/1ps
// Pin-level checks on the serial data and interrupt pins
module rct_timer_asserts (
  input wire clk,
  input wire resetn,
  input wire osc_32k,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe,
  input wire int_n_o,
  input wire int_n_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  rst_quiet_a: assert property (disable iff (1'b0) !resetn |=> !int_n_oe && !sda_oe)
    else $error("pins not released after reset");
  irq_drive_a: assert property (int_n_o == 1'b0)
    else $error("interrupt pin not driven low");
  sda_low_a: assert property (sda_o == 1'b0)
    else $error("data pin drive value not low");
  irq_hold_a: assert property (int_n_oe && scl_i |=> int_n_oe)
    else $error("interrupt dropped without a bus write");
  irq_clear_a: assert property ($fell(int_n_oe) |-> !scl_i && !$past(scl_i, 3))
    else $error("interrupt released outside a write slot");
  irq_stays_a: assert property ($rose(int_n_oe) |-> int_n_oe [*8])
    else $error("interrupt pulse too short");
  ack_low_a: assert property ($rose(sda_oe) |-> !scl_i && !$past(scl_i, 2))
    else $error("data pulled while clock high");
  ack_hold_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("data moved while clock high");
  ack_free_a: assert property ($rose(sda_oe) |-> ##[1:400] !sda_oe)
    else $error("data line held too long");
endmodule
bind rct_timer rct_timer_asserts i_chk (.clk(clk), .resetn(resetn), .osc_32k(osc_32k),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .int_n_o(int_n_o),
  .int_n_oe(int_n_oe));

// file: test/rct_host_model.sv
`timescale 1ns/1ps
// Host bus master; every change lands just after a clk edge
module rct_host_model #(
  parameter [6:0] DEV = 7'h52 // Device address, arbitrary value
) (
  input wire clk,
  input wire sda,
  output reg scl = 1'b1,
  output reg sda_low = 1'b0
);
  reg nak = 1'b0; // Sticky: a byte went unacknowledged
  task w(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // One 20 clk bit slot; data moves only while the clock is low
  task bit_io(input b, output r);
    begin
      scl <= 1'b0;
      w(4);
      sda_low <= !b;
      w(6);
      scl <= 1'b1;
      w(5);
      r = sda;
      w(5);
    end
  endtask
  // Data edge under a high clock: fall is a start, rise a stop
  task edge_hi(input fall);
    begin
      scl <= 1'b0;
      w(5);
      sda_low <= !fall;
      w(5);
      scl <= 1'b1;
      w(10);
      sda_low <= fall;
      w(10);
    end
  endtask
  // Byte plus ack slot; all-ones bytes are reads, so their ack is ours
  task byte_io(input [7:0] d, input hb, output [7:0] q);
    integer i;
    reg a;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(d[i], q[i]);
      bit_io(hb, a);
      nak = nak | (a & (d != 8'hff));
    end
  endtask
  task wr(input [7:0] adr, input [7:0] ofs, input [7:0] d);
    reg [7:0] q;
    begin
      edge_hi(1'b1);
      byte_io(adr, 1'b1, q);
      byte_io(ofs, 1'b1, q);
      byte_io(d, 1'b1, q);
      edge_hi(1'b0);
    end
  endtask
  // Pointer write, repeated start, one byte closed by no ack
  task rd(input [7:0] ofs, output [7:0] q);
    begin
      edge_hi(1'b1);
      byte_io({DEV, 1'b0}, 1'b1, q);
      byte_io(ofs, 1'b1, q);
      edge_hi(1'b1);
      byte_io({DEV, 1'b1}, 1'b1, q);
      byte_io(8'hff, 1'b1, q);
      edge_hi(1'b0);
    end
  endtask
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0;
  reg resetn = 1'b0; // Active low
  reg osc_32k = 1'b0; // Sped up: one toggle every 2 clk
  reg osc_div = 1'b0; // Toggle phase of the sped-up oscillator
  wire scl;
  wire sda_low;
  wire sda_oe;
  wire int_n_oe;
  wire sda = !(sda_low || sda_oe); // Pull-up unless pulled low
  wire int_n = !int_n_oe; // Open drain with pull-up
  integer error_cnt = 0;
  integer n_checks = 0;
  integer cyc = 0; // Hang guard
  integer k;
  integer t0;
  reg [31:0] seed = 32'hf3fd;
  reg [7:0] q;
  rct_host_model i_rct_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  rct_timer i_rct_timer (.clk(clk), .resetn(resetn), .osc_32k(osc_32k), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .int_n_o(), .int_n_oe(int_n_oe));
  always #10 clk = !clk;
  always @(posedge clk) begin
    osc_div <= !osc_div;
    osc_32k <= osc_div ? !osc_32k : osc_32k;
    cyc <= cyc + 1;
    // Whole run needs under 90000 cycles at this oscillator speed
    if (cyc == 95000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish;
    end
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Clock cycles per tick, 4 clk per oscillator period
  function integer tick(input [1:0] s);
    tick = 4 * (s == 2'h0 ? 1024 : s == 2'h1 ? 4096 : s == 2'h2 ? 32768 : 65536);
  endfunction
  // Control after a write: select and reload frozen while running
  function [7:0] ctrl(input [7:0] old, input [7:0] d);
    ctrl = old[1] ? {1'b0, old[6:5], 2'h0, old[2], d[1], 1'b0} : (d & 8'h66);
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: %h, expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] o, input [7:0] d);
    i_rct_host_model.wr(8'ha4, o, d);
  endtask
  task rdc(input [7:0] o, input [7:0] e);
    begin
      i_rct_host_model.rd(o, q);
      chk(q, e);
    end
  endtask
  // Bounded wait for the interrupt pin
  task wait_int;
    begin
      k = 0;
      while (int_n !== 1'b0 && k < 60000) begin
        @(posedge clk);
        k = k + 1;
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (error_cnt == 0 && n_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(8'h00, 8'h00);
    rdc(8'h07, 8'h00);
    i_rct_host_model.wr(8'h44, 8'h01, 8'h02);
    chk(i_rct_host_model.nak, 1'b1);
    i_rct_host_model.nak = 1'b0;
    rdc(8'h01, 8'h00);
    seed = lfsr(seed);
    wr(8'h18, seed[7:0]);
    wr(8'h19, seed[15:8]);
    rdc(8'h18, seed[7:0]);
    rdc(8'h19, seed[15:8]);
    for (k = 0; k < 4; k = k + 1) begin
      wr(8'h00, {1'b0, k[1:0], 5'h04});
      rdc(8'h00, ctrl(8'h00, {1'b0, k[1:0], 5'h04}));
    end
    // Reload now set, so the count must refuse writes
    wr(8'h18, 8'h02);
    rdc(8'h18, seed[7:0]);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'hff);
    rdc(8'h01, 8'h02);
    wr(8'h18, 8'h02);
    wr(8'h19, 8'h00);
    wr(8'h00, 8'h06);
    wait_int;
    chk(k <= 2 * tick(0), 1);
    t0 = cyc;
    rdc(8'h02, 8'h02);
    chk(int_n, 1'b0);
    wr(8'h00, 8'h66);
    rdc(8'h00, ctrl(8'h06, 8'h66));
    wr(8'h18, 8'h05);
    rdc(8'h18, 8'h02);
    wr(8'h02, 8'h00);
    chk(int_n, 1'b1);
    wait_int;
    chk((cyc - t0 >= 3 * tick(0) - 2) && (cyc - t0 <= 3 * tick(0) + 2), 1);
    wr(8'h00, 8'h00);
    rdc(8'h00, ctrl(8'h06, 8'h00));
    wr(8'h00, 8'h00);
    wr(8'h02, 8'h00);
    wr(8'h00, 8'h20);
    wr(8'h00, 8'h22);
    wait_int;
    chk((k > tick(1) - 100) && (k <= 2 * tick(1)), 1);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(int_n, 1'b1);
    rdc(8'h01, 8'h00);
    // Zero count after reset: running with the interrupt enabled never ends
    wr(8'h01, 8'h02);
    wr(8'h00, 8'h02);
    repeat (tick(0) + 100) @(posedge clk);
    chk(int_n, 1'b1);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h18, 8'h01);
    wr(8'h00, 8'h02);
    repeat (tick(0) + 100) @(posedge clk);
    chk(int_n, 1'b1);
    rdc(8'h02, 8'h00);
    chk(i_rct_host_model.nak, 1'b0);
    tally_and_finish;
  end
endmodule
